// File: src/cspsc_ctrl.sv
// Clock switch and power-save controller with Avalon-MM register slave.
// Assumes the core sequences its register writes and raises power_save_instr_req for
// one cycle per power-save instruction; all inputs are synchronous to clk.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "cspsc_map.svh"
module cspsc_ctrl
  import cspsc_pkg::*;
#(
  parameter int SWITCH_CYC = `CSPSC_SWITCH_CYC,
  parameter int PIO_W      = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Avalon-MM slave
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [3:0]       avs_byteenable,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // Core power-save request and wake events
  input  wire logic             power_save_instr_req,
  input  wire logic             power_save_instr_idle,
  input  wire logic             irq_pending,
  input  wire logic             wdt_timeout,
  input  wire logic             wdt_enabled,
  input  wire logic             fsm_enabled,
  input  wire logic             rc_selected,
  // Oscillator status
  input  wire logic             pll_lock,
  input  wire logic             prim_tick,
  input  wire logic             sys_tick,
  // I/O pin state from port logic
  input  wire logic [PIO_W-1:0] pio_out_in,
  input  wire logic [PIO_W-1:0] pio_oe_in,
  // Clock and power outputs
  output logic [2:0]            sys_src,
  output logic                  sys_clk_run,
  output logic                  prim_osc_on,
  output logic                  rc_osc_on,
  output logic                  cpu_clk_run,
  output logic                  periph_sys_en,
  output logic                  wdt_clear,
  output logic                  fsm_active,
  output logic                  wake_pulse,
  // Pins
  output logic [PIO_W-1:0]      pio_out,
  output logic [PIO_W-1:0]      pio_oe,
  output logic                  ref_clock_pin
);

  logic         acc_osc;
  logic         wr_osc;
  logic         hi_open;
  logic         lo_open;
  logic         ack_q;
  logic         ack_d;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;
  cspsc_src_t   cur_src_q;
  cspsc_src_t   cur_src_d;
  cspsc_src_t   new_src_q;
  cspsc_src_t   new_src_d;
  logic         swreq_q;
  logic         swreq_d;
  logic [15:0]  swcnt_q;
  logic [15:0]  swcnt_d;
  logic [15:0]  ref_ctrl_q;
  logic [15:0]  ref_ctrl_d;
  cspsc_pmode_e pm_q;
  cspsc_pmode_e pm_d;
  logic         hold_q;
  logic         hold_d;
  logic         wdt_clr_q;
  logic         wdt_clr_d;
  logic         wake_q;
  logic         wake_d;
  logic [PIO_W-1:0] frz_out_q;
  logic [PIO_W-1:0] frz_out_d;
  logic [PIO_W-1:0] frz_oe_q;
  logic [PIO_W-1:0] frz_oe_d;
  logic         is_prim;
  logic         ro_run;
  logic         bus_req;
  logic         wake_ev;

  assign bus_req = (avs_read || avs_write) && !ack_q;
  assign acc_osc = bus_req;
  assign wr_osc  = avs_write && (avs_address == `CSPSC_OSC_CTRL_OFS);
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata    = rdata_q;

  cspsc_unlock #(
    .KEY1 (`CSPSC_KEY_HI_1),
    .KEY2 (`CSPSC_KEY_HI_2)
  ) u_unlock_hi (
    .clk     (clk),
    .resetn  (resetn),
    .acc     (acc_osc),
    .wr_lane (wr_osc && avs_byteenable[1]),
    .wdata   (avs_writedata[15:8]),
    .open    (hi_open)
  );

  cspsc_unlock #(
    .KEY1 (`CSPSC_KEY_LO_1),
    .KEY2 (`CSPSC_KEY_LO_2)
  ) u_unlock_lo (
    .clk     (clk),
    .resetn  (resetn),
    .acc     (acc_osc),
    .wr_lane (wr_osc && avs_byteenable[0]),
    .wdata   (avs_writedata[7:0]),
    .open    (lo_open)
  );

  assign is_prim = (cur_src_q < 3'h4);
  // sleep output needs both bits and a primary source
  assign ro_run = ref_ctrl_q[`CSPSC_RO_ON_BIT] &&
                  ((pm_q != CSPSC_PM_SLEEP) ||
                   (ref_ctrl_q[`CSPSC_RO_SLP_BIT] &&
                    ref_ctrl_q[`CSPSC_RO_SEL_BIT] && is_prim));

  cspsc_refclk #(
    .DIV_W (4)
  ) u_refclk (
    .clk       (clk),
    .resetn    (resetn),
    .run       (ro_run),
    .src_sel   (ref_ctrl_q[`CSPSC_RO_SEL_BIT]),
    .div       (ref_ctrl_q[`CSPSC_RO_DIV_LSB+3:`CSPSC_RO_DIV_LSB]),
    .prim_tick (prim_tick),
    .sys_tick  (sys_tick && (pm_q != CSPSC_PM_SLEEP)),
    .ref_out   (ref_clock_pin)
  );

  // Bus slave: answer one cycle after the request is seen
  always_comb begin
    ack_d      = bus_req;
    rdata_d    = rdata_q;
    ref_ctrl_d = ref_ctrl_q;
    new_src_d  = new_src_q;
    if (bus_req && avs_read) begin
      unique case (avs_address)
        `CSPSC_OSC_CTRL_OFS: rdata_d = {16'h0000, 1'b0, cur_src_q,
                                        1'b0, new_src_q, 2'b00,
                                        pll_lock, 4'h0, swreq_q};
        `CSPSC_REF_OUT_CTRL_OFS: rdata_d = {16'h0000, ref_ctrl_q};
        `CSPSC_STATUS_OFS: rdata_d = {29'h0, pm_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (bus_req && avs_write &&
        avs_address == `CSPSC_REF_OUT_CTRL_OFS) begin
      if (avs_byteenable[0]) ref_ctrl_d[7:0]  = avs_writedata[7:0];
      if (avs_byteenable[1]) ref_ctrl_d[15:8] = avs_writedata[15:8];
    end
    // new source only in unlocked slot
    if (hi_open) begin
      new_src_d = avs_writedata[`CSPSC_NOSRC_LSB+2:`CSPSC_NOSRC_LSB];
    end
  end

  // Clock switch: request set only in the low unlock slot
  always_comb begin
    swreq_d   = swreq_q;
    swcnt_d   = swcnt_q;
    cur_src_d = cur_src_q;
    if (lo_open && avs_writedata[`CSPSC_SWREQ_BIT]) begin
      swreq_d = 1'b1;
      swcnt_d = 16'h0000;
    end else if (swreq_q && pm_q == CSPSC_PM_RUN) begin
      // clear on success, hold on no lock
      if (swcnt_q >= 16'(SWITCH_CYC - 1)) begin
        if (pll_lock) begin
          swreq_d   = 1'b0;
          cur_src_d = new_src_q;
        end
      end else begin
        swcnt_d = swcnt_q + 16'h0001;
      end
    end
  end

  assign wake_ev = irq_pending || wdt_timeout;

  // Power-save mode sequencer
  always_comb begin
    pm_d      = pm_q;
    hold_d    = hold_q;
    wdt_clr_d = 1'b0;
    wake_d    = 1'b0;
    frz_out_d = frz_out_q;
    frz_oe_d  = frz_oe_q;
    unique case (pm_q)
      CSPSC_PM_RUN: begin
        if (power_save_instr_req) begin
          pm_d = power_save_instr_idle ? CSPSC_PM_IDLE : CSPSC_PM_SLEEP;
          wdt_clr_d = wdt_enabled;
          hold_d = wake_ev;
          frz_out_d = pio_out_in;
          frz_oe_d  = pio_oe_in;
        end
      end
      CSPSC_PM_SLEEP, CSPSC_PM_IDLE: begin
        if (wake_ev || hold_q) begin
          pm_d   = CSPSC_PM_RUN;
          hold_d = 1'b0;
          wake_d = 1'b1;
        end
      end
      default: pm_d = CSPSC_PM_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q      <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      ref_ctrl_q <= `CSPSC_REF_CTRL_RST;
      new_src_q  <= `CSPSC_OSC_SRC_RST;
      cur_src_q  <= `CSPSC_OSC_SRC_RST;
      swreq_q    <= 1'b0;
      swcnt_q    <= 16'h0000;
      pm_q       <= CSPSC_PM_RUN;
      hold_q     <= 1'b0;
      wdt_clr_q  <= 1'b0;
      wake_q     <= 1'b0;
      frz_out_q  <= '0;
      frz_oe_q   <= '0;
    end else begin
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      ref_ctrl_q <= ref_ctrl_d;
      new_src_q  <= new_src_d;
      cur_src_q  <= cur_src_d;
      swreq_q    <= swreq_d;
      swcnt_q    <= swcnt_d;
      pm_q       <= pm_d;
      hold_q     <= hold_d;
      wdt_clr_q  <= wdt_clr_d;
      wake_q     <= wake_d;
      frz_out_q  <= frz_out_d;
      frz_oe_q   <= frz_oe_d;
    end
  end

  assign sys_src    = cur_src_q;
  assign wdt_clear  = wdt_clr_q;
  assign wake_pulse = wake_q;
  assign sys_clk_run   = (pm_q != CSPSC_PM_SLEEP);
  assign cpu_clk_run   = (pm_q == CSPSC_PM_RUN);
  assign periph_sys_en = (pm_q != CSPSC_PM_SLEEP);
  assign fsm_active    = fsm_enabled && (pm_q != CSPSC_PM_SLEEP);
  // primary powers down unless kept for reference
  assign prim_osc_on   = is_prim && (pm_q != CSPSC_PM_SLEEP || ro_run);
  // RC oscillator kept for selecting modules
  assign rc_osc_on = rc_selected || wdt_enabled || fsm_enabled;
  assign pio_out = (pm_q == CSPSC_PM_SLEEP) ? frz_out_q : pio_out_in;
  assign pio_oe  = (pm_q == CSPSC_PM_SLEEP) ? frz_oe_q  : pio_oe_in;

endmodule : cspsc_ctrl

// File: src/cspsc_map.svh
// Register map, field positions, reset values and timing counts for the
// clock switch and power-save controller.
// Assumes a 32-bit Avalon-MM slave whose address carries the byte offsets directly.
`ifndef CSPSC_MAP_SVH
`define CSPSC_MAP_SVH

// Byte offsets
`define CSPSC_OSC_CTRL_OFS      8'h00
`define CSPSC_REF_OUT_CTRL_OFS  8'h04
`define CSPSC_PWR_CTRL_OFS      8'h08
`define CSPSC_STATUS_OFS        8'h0C

// Unlock keys
`define CSPSC_KEY_HI_1          8'h78
`define CSPSC_KEY_HI_2          8'h9A
`define CSPSC_KEY_LO_1          8'h46
`define CSPSC_KEY_LO_2          8'h57

// Oscillator control fields
`define CSPSC_NOSRC_LSB         8
`define CSPSC_CURSRC_LSB        12
`define CSPSC_SWREQ_BIT         0
`define CSPSC_LOCK_BIT          5

// Reference output fields
`define CSPSC_RO_ON_BIT         15
`define CSPSC_RO_SLP_BIT        13
`define CSPSC_RO_SEL_BIT        12
`define CSPSC_RO_DIV_LSB        8

// Power control fields
`define CSPSC_PWR_SLEEP_BIT     0
`define CSPSC_PWR_IDLE_BIT      1

// Reset values
`define CSPSC_OSC_SRC_RST       3'h0
`define CSPSC_REF_CTRL_RST      16'h0000

// Oscillator settle time before a switch completes
`define CSPSC_SWITCH_NS         1000
`define CSPSC_CLK_NS            25
`define CSPSC_SWITCH_CYC  ((`CSPSC_SWITCH_NS+`CSPSC_CLK_NS-1)/`CSPSC_CLK_NS)

`endif

// File: src/cspsc_pkg.sv
// Types shared by the clock switch and power-save controller.
// Assumes the map header carries all numeric constants.
package cspsc_pkg;

  typedef enum logic [3:0] {
    CSPSC_UL_IDLE = 4'h1,
    CSPSC_UL_KEY1 = 4'h2,
    CSPSC_UL_OPEN = 4'h4,
    CSPSC_UL_SPARE = 4'h8
  } cspsc_unlock_e;

  typedef enum logic [2:0] {
    CSPSC_PM_RUN   = 3'h1,
    CSPSC_PM_SLEEP = 3'h2,
    CSPSC_PM_IDLE  = 3'h4
  } cspsc_pmode_e;

  // Primary source codes are those below 3'h4 by convention here
  typedef logic [2:0] cspsc_src_t;

endpackage : cspsc_pkg

// File: src/cspsc_refclk.sv
// Reference clock generator: source choice, divider and glitch-free gate.
// Assumes both sources are given as enable pulses in the clk domain.
`timescale 1ns/100ps
module cspsc_refclk #(
  parameter int DIV_W = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             run,
  input  wire logic             src_sel,
  input  wire logic [DIV_W-1:0] div,
  // Source ticks
  input  wire logic             prim_tick,
  input  wire logic             sys_tick,
  // Reference clock output
  output logic                  ref_out
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        lvl_q;
  logic        lvl_d;
  logic        on_q;
  logic        on_d;
  logic        tick;
  logic [15:0] half;

  assign tick = src_sel ? prim_tick : sys_tick;
  // sixteen division ratios
  // Toggle every 2^div ticks, so each code gives its own ratio
  assign half = (16'h0001 << div) - 16'h0001;
  assign ref_out = lvl_q & on_q;

  always_comb begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    on_d  = on_q;
    if (tick) begin
      if (cnt_q >= half) begin
        cnt_d = 16'h0000;
        lvl_d = ~lvl_q;
        // gate changes only at low edge
        if (lvl_q) begin
          on_d = run;
        end
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
    if (!on_q && !lvl_q && run) begin
      on_d = 1'b1;
    end
    if (!run && !on_q) begin
      cnt_d = 16'h0000;
      lvl_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
      lvl_q <= 1'b0;
      on_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      on_q  <= on_d;
    end
  end

endmodule : cspsc_refclk

// File: src/cspsc_unlock.sv
// One keyed unlock for a byte lane of the oscillator control register.
// Assumes one acc strobe per bus access, read or write, to any register.
`timescale 1ns/100ps
`include "cspsc_map.svh"
module cspsc_unlock
  import cspsc_pkg::*;
#(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Access stream
  input  wire logic       acc,
  input  wire logic       wr_lane,
  input  wire logic [7:0] wdata,
  // Protected write permitted this access
  output logic            open
);

  cspsc_unlock_e st_q;
  cspsc_unlock_e st_d;

  assign open = acc && wr_lane && (st_q == CSPSC_UL_OPEN);

  always_comb begin
    st_d = st_q;
    if (acc) begin
      st_d = CSPSC_UL_IDLE;
      unique case (st_q)
        CSPSC_UL_IDLE: begin
          if (wr_lane && wdata == KEY1) begin
            st_d = CSPSC_UL_KEY1;
          end
        end
        CSPSC_UL_KEY1: begin
          if (wr_lane && wdata == KEY2) begin
            st_d = CSPSC_UL_OPEN;
          end else if (wr_lane && wdata == KEY1) begin
            st_d = CSPSC_UL_KEY1;
          end
        end
        CSPSC_UL_OPEN: st_d = CSPSC_UL_IDLE;
        default:       st_d = CSPSC_UL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= CSPSC_UL_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : cspsc_unlock

// File: test/cspsc_core_model.sv
// Core model: register transfers and power-save requests.
// Assumes a slave that answers by lowering waitrequest.
`timescale 1ns/100ps
`include "cspsc_map.svh"
module cspsc_core_model (
  // Clock
  input  wire logic        clk,
  // Avalon-MM master
  output logic [7:0]       avs_address    = 8'h00,
  output logic             avs_read       = 1'b0,
  output logic             avs_write      = 1'b0,
  output logic [3:0]       avs_byteenable = 4'h0,
  output logic [31:0]      avs_writedata  = 32'h0,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Power-save instruction
  output logic             power_save_instr_req     = 1'b0,
  output logic             power_save_instr_idle    = 1'b0
);
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] q);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic osc_switch(input logic [2:0] src, input logic brk);
    logic [31:0] q;
    bus(1'b1, 8'h00, 4'h2, {16'h0, `CSPSC_KEY_HI_1, 8'h00}, q);
    if (brk) bus(1'b0, `CSPSC_STATUS_OFS, 4'hF, 32'h0, q);
    bus(1'b1, 8'h00, 4'h2, {16'h0, `CSPSC_KEY_HI_2, 8'h00}, q);
    bus(1'b1, 8'h00, 4'h2, {21'h0, src, 8'h00}, q);
    bus(1'b1, 8'h00, 4'h1, {24'h0, `CSPSC_KEY_LO_1}, q);
    bus(1'b1, 8'h00, 4'h1, {24'h0, `CSPSC_KEY_LO_2}, q);
    bus(1'b1, 8'h00, 4'h1, 32'h1, q);
  endtask : osc_switch

  task automatic power_save_instr(input logic idle);
    power_save_instr_idle <= idle;
    power_save_instr_req <= 1'b1;
    @(posedge clk);
    power_save_instr_req <= 1'b0;
  endtask : power_save_instr
endmodule : cspsc_core_model

// File: test/cspsc_ctrl_props.sv
// Port checker for the clock switch and power-save controller.
// Assumes binding to cspsc_ctrl; one clock domain.
`timescale 1ns/100ps
module cspsc_ctrl_props #(
  parameter int PIO_W = 16
) (
  // Clock, reset and bus
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  // Core events
  input wire logic             power_save_instr_req,
  input wire logic             power_save_instr_idle,
  input wire logic             irq_pending,
  input wire logic             wdt_timeout,
  input wire logic             wdt_enabled,
  input wire logic             fsm_enabled,
  input wire logic             rc_selected,
  // Outputs watched
  input wire logic [2:0]       sys_src,
  input wire logic             sys_clk_run,
  input wire logic             cpu_clk_run,
  input wire logic             periph_sys_en,
  input wire logic             wdt_clear,
  input wire logic             fsm_active,
  input wire logic             rc_osc_on,
  input wire logic             wake_pulse,
  input wire logic [PIO_W-1:0] pio_out,
  input wire logic [PIO_W-1:0] pio_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence run_s;
    cpu_clk_run && sys_clk_run;
  endsequence
  sequence slp_s;
    !sys_clk_run ##1 !sys_clk_run;
  endsequence
  bus_wait_a:
  assert property ($rose(avs_read || avs_write) |-> avs_waitrequest
    ##1 !avs_waitrequest) else $error("bus wait state wrong");
  slp_entry_a:
  assert property (power_save_instr_req && !power_save_instr_idle && cpu_clk_run |=>
    !sys_clk_run) else $error("sleep not entered");
  slp_gate_a:
  assert property (!sys_clk_run |-> !periph_sys_en && !fsm_active
    && !cpu_clk_run) else $error("clock users alive in sleep");
  idle_entry_a:
  assert property (power_save_instr_req && power_save_instr_idle && cpu_clk_run |=>
    !cpu_clk_run && sys_clk_run && periph_sys_en)
    else $error("idle entry wrong");
  pin_freeze_a:
  assert property (slp_s |-> $stable(pio_out) && $stable(pio_oe))
    else $error("pins moved in sleep");
  src_hold_a:
  assert property (!sys_clk_run || wake_pulse |-> $stable(sys_src))
    else $error("source changed over sleep");
  wdt_clr_a:
  assert property (power_save_instr_req && wdt_enabled && cpu_clk_run |=>
    wdt_clear ##1 !wdt_clear) else $error("watchdog not cleared");
  rc_keep_a:
  assert property ((!sys_clk_run && rc_selected) || (!cpu_clk_run &&
    sys_clk_run && (wdt_enabled || fsm_enabled)) |-> rc_osc_on)
    else $error("rc oscillator off");
  wake_a:
  assert property (!cpu_clk_run && (irq_pending || wdt_timeout) |->
    ##[0:3] wake_pulse) else $error("no wake");
  wake_run_a:
  assert property (wake_pulse |-> ##[0:1] run_s)
    else $error("clock not restored");
  coin_irq_a:
  assert property (power_save_instr_req && cpu_clk_run && irq_pending |=>
    !cpu_clk_run ##[0:3] wake_pulse) else $error("coincident irq lost");
endmodule : cspsc_ctrl_props

bind cspsc_ctrl cspsc_ctrl_props #(.PIO_W(PIO_W)) i_props (
  .clk, .resetn, .avs_read, .avs_write, .avs_waitrequest, .power_save_instr_req,
  .power_save_instr_idle, .irq_pending, .wdt_timeout, .wdt_enabled, .fsm_enabled,
  .rc_selected, .sys_src, .sys_clk_run, .cpu_clk_run, .periph_sys_en,
  .wdt_clear, .fsm_active, .rc_osc_on, .wake_pulse, .pio_out, .pio_oe);

// File: test/cspsc_ctrl_tb_top.sv
// Testbench for the clock switch and power-save controller.
// Assumes the core model and the bound port checker.
`timescale 1ns/100ps
module cspsc_ctrl_tb_top;
  typedef struct { logic [15:0] ctl; int half; } cspsc_row_s;
  logic clk = 1'b0, resetn = 1'b0, pll_lock = 1'b1;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, power_save_instr_req, power_save_instr_idle;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic irq_pending = 1'b0, wdt_timeout = 1'b0, wdt_enabled = 1'b0;
  logic fsm_enabled = 1'b0, rc_selected = 1'b0, s;
  logic prim_tick = 1'b0, sys_tick = 1'b0;
  logic [15:0] pio_out_in = 16'h0, pio_oe_in = 16'h0, pio_out, pio_oe;
  logic [2:0] sys_src;
  logic sys_clk_run, prim_osc_on, rc_osc_on, cpu_clk_run, periph_sys_en;
  logic wdt_clear, fsm_active, wake_pulse, ref_clock_pin;
  int n_errors = 0, check_count = 0, cyc = 0, n;
  cspsc_row_s rows [7] = '{'{16'h8000, 2}, '{16'h8100, 4},
    '{16'h8300, 16}, '{16'h8500, 64}, '{16'h9000, 3}, '{16'h9200, 12},
    '{16'h0300, 300}};

  cspsc_ctrl #(.SWITCH_CYC(2)) i_dut (.clk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .power_save_instr_req, .power_save_instr_idle, .irq_pending,
    .wdt_timeout, .wdt_enabled, .fsm_enabled, .rc_selected, .pll_lock,
    .prim_tick, .sys_tick, .pio_out_in, .pio_oe_in, .sys_src,
    .sys_clk_run, .prim_osc_on, .rc_osc_on, .cpu_clk_run, .periph_sys_en,
    .wdt_clear, .fsm_active, .wake_pulse, .pio_out, .pio_oe,
    .ref_clock_pin);
  cspsc_core_model i_core (.clk, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .power_save_instr_req, .power_save_instr_idle);

  always #12.5 clk = ~clk;

  // System tick slows when a non-default source is running
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prim_tick <= (cyc % 3) == 0;
    sys_tick <= (cyc % ((sys_src === 3'h0) ? 2 : 4)) == 0;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task automatic chk_reg(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_sig(input string nm, input logic [15:0] e, g);
    chk_reg(nm, {16'h0, e}, {16'h0, g});
  endtask : chk_sig

  task automatic half_per(output int k);
    logic p;
    k = 0;
    p = ref_clock_pin;
    while (ref_clock_pin === p && k < 300) begin
      @(posedge clk);
      k++;
    end
  endtask : half_per

  task automatic ref_check(input logic [15:0] ctl, input int half);
    i_core.bus(1'b1, 8'h04, 4'h3, {16'h0, ctl}, q);
    half_per(n);
    half_per(n);
    half_per(n);
    chk_reg("ref half period", half, n);
  endtask : ref_check

  task automatic wake_wait;
    s = 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (wake_pulse === 1'b1) s = 1'b1;
    end
    chk_sig("wake", 16'h1, {15'h0, s});
    irq_pending <= 1'b0;
    i_core.bus(1'b0, 8'h0C, 4'hF, 32'h0, q);
    chk_reg("mode after wake", 32'h1, q & 32'h7);
  endtask : wake_wait

  task automatic end_sim;
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      ref_check(rows[i].ctl, rows[i].half);
      i_core.bus(1'b0, 8'h04, 4'hF, 32'h0, q);
      chk_reg("ref ctrl", {16'h0, rows[i].ctl}, q);
    end
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a += 4) begin
      i_core.bus(1'b0, a[7:0], 4'hF, 32'h0, q);
      chk_reg("reset value", (a == 0) ? 32'h20 : (a == 12), q);
    end
    i_core.osc_switch(3'h5, 1'b0);
    repeat (8) @(posedge clk);
    chk_sig("source", 16'h5, {13'h0, sys_src});
    ref_check(16'h8100, 8);
    i_core.osc_switch(3'h2, 1'b1);
    repeat (8) @(posedge clk);
    chk_sig("broken unlock", 16'h5, {13'h0, sys_src});
    pll_lock <= 1'b0;
    i_core.osc_switch(3'h1, 1'b0);
    repeat (8) @(posedge clk);
    i_core.bus(1'b0, 8'h00, 4'hF, 32'h0, q);
    chk_reg("failed switch", 32'h1, q & 32'h21);
    pll_lock <= 1'b1;
    repeat (8) @(posedge clk);
    chk_sig("late lock", 16'h1, {13'h0, sys_src});
    i_core.bus(1'b1, 8'h04, 4'h3, 32'hB000, q);
    pio_out_in <= 16'hA5A5;
    pio_oe_in <= 16'h00FF;
    rc_selected <= 1'b1;
    wdt_enabled <= 1'b1;
    i_core.power_save_instr(1'b0);
    pio_out_in <= 16'h0000;
    pio_oe_in <= 16'hFFFF;
    @(posedge clk);
    chk_sig("sleep gates", 16'h3, {14'h0, prim_osc_on, rc_osc_on});
    chk_sig("sys clock", 16'h0, {15'h0, sys_clk_run});
    half_per(n);
    half_per(n);
    chk_reg("ref in sleep", 32'h3, n);
    chk_sig("pin state", 16'hA5A5, pio_out);
    chk_sig("pin dir", 16'h00FF, pio_oe);
    irq_pending <= 1'b1;
    wake_wait();
    chk_sig("resume src", 16'h1, {13'h0, sys_src});
    chk_sig("pin follow", 16'h0000, pio_out);
    i_core.bus(1'b1, 8'h04, 4'h3, 32'h9000, q);
    i_core.power_save_instr(1'b0);
    @(posedge clk);
    chk_sig("prim off", 16'h0, {15'h0, prim_osc_on});
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    wake_wait();
    fsm_enabled <= 1'b1;
    i_core.power_save_instr(1'b1);
    @(posedge clk);
    chk_sig("idle run", 16'h2, {14'h0, sys_clk_run, cpu_clk_run});
    irq_pending <= 1'b1;
    wake_wait();
    // Interrupt only in the entry cycle: the held copy must wake
    irq_pending <= 1'b1;
    i_core.power_save_instr(1'b1);
    irq_pending <= 1'b0;
    wake_wait();
    end_sim();
  end
endmodule : cspsc_ctrl_tb_top
